/* File: design/tls_top.sv */
// Summary of operation
// - forward/reverse torque clamped by selected limits
// - internal limits 0..350, reset 300, immediate
// - external limits 0..350, reset 100, immediate
// - forward request on: min of internal, external
// - forward request off: forward external alone
// - reverse request on: min of internal, external
// - reverse request off: reverse external alone
// - status output high exactly while clamping
// - bus at threshold raises warning, cuts current
// - undervoltage limit is percent of internal
// - reduced limit held for release time
// - ride through loss for hold cycles
// - decay option slows bus fall in undervoltage
// - servo off command removes motor power now
// - no limit above motor maximum torque
// - input codes 3 and 4 route requests
// - output code 3 routes limiting status
`timescale 1ns/1ps
`default_nettype none
`include "tls_params.svh"
module tls_top
	import tls_pkg::*;
#(
	parameter int TW        = 16,
	parameter int NIN       = 5,
	parameter int NOUT      = 3,
	parameter int MS_CYC    = `TLS_MS_NS / `TLS_CLK_NS,
	parameter int HOLD_CYC  = `TLS_CYC_MS * MS_CYC
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [NIN-1:0]       din,
	output logic      [NOUT-1:0]      dout,
	input  wire logic                 servo_on_in,
	input  wire logic                 supply_lost_in,
	input  wire logic [11:0]          bus_level,
	input  wire logic signed [TW-1:0] torque_ref,
	output logic signed [TW-1:0]      torque_cmd,
	output logic                      limiting_status_out,
	output logic                      undervoltage_warning,
	output logic                      current_reduce_out,
	output logic                      decay_slow_out,
	output logic                      motor_power_out,
	output logic                      alarm_stop_out
);
	// ----------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------
	if (TW < 11 || NIN < 1 || NIN > 8 || NOUT < 1 || NOUT > 8 ||
		MS_CYC < 1 || HOLD_CYC < 1) begin : g_chk
		$error("tls_top: unsupported parameter value");
	end

	tls_lim_t     fwd_int_q, rev_int_q, fwd_ext_q, rev_ext_q, mmax_q;
	tls_pct_t     uv_pct_q;
	logic [9:0]   uv_rel_q;
	logic [5:0]   hold_q;
	logic [2:0]   ctrl_q;
	logic [15:0]  in_a_q, in_b_q;
	logic [31:0]  out_q;
	logic [11:0]  thr_q;
	logic         alarm_q, limit_q, uvw_q, pwr_q;
	logic [31:0]  rd_d;
	logic         hit;
	logic         wr, wr_stat;
	tls_uv_e      uv_q;
	logic         uv_act;

	function automatic logic [31:0] sat(input logic [31:0] v,
		input logic [31:0] m);
		sat = (v > m) ? m : v;
	endfunction

	// ----------------------------------------------------------
	// apb slave: zero wait, error on unmapped offsets
	// ----------------------------------------------------------
	assign pready  = 1'b1;
	assign wr      = psel & penable & pwrite & hit;
	assign wr_stat = wr && (paddr == `TLS_A_STATUS);
	assign pslverr = psel & penable & ~hit;

	// read mux and decode
	always_comb begin
		hit  = 1'b1;
		rd_d = 32'h00000000;
		if (paddr == `TLS_A_FWD_INT) begin
			rd_d = 32'(fwd_int_q);
		end else if (paddr == `TLS_A_REV_INT) begin
			rd_d = 32'(rev_int_q);
		end else if (paddr == `TLS_A_FWD_EXT) begin
			rd_d = 32'(fwd_ext_q);
		end else if (paddr == `TLS_A_REV_EXT) begin
			rd_d = 32'(rev_ext_q);
		end else if (paddr == `TLS_A_UV_PCT) begin
			rd_d = 32'(uv_pct_q);
		end else if (paddr == `TLS_A_UV_REL) begin
			rd_d = 32'(uv_rel_q);
		end else if (paddr == `TLS_A_HOLD) begin
			rd_d = 32'(hold_q);
		end else if (paddr == `TLS_A_CTRL) begin
			rd_d = 32'(ctrl_q);
		end else if (paddr == `TLS_A_IN_A) begin
			rd_d = 32'(in_a_q);
		end else if (paddr == `TLS_A_IN_B) begin
			rd_d = 32'(in_b_q);
		end else if (paddr == `TLS_A_OUT) begin
			rd_d = out_q;
		end else if (paddr == `TLS_A_STATUS) begin
			rd_d[`TLS_S_CLT] = limit_q;
			rd_d[`TLS_S_UVW] = uvw_q;
			rd_d[`TLS_S_UVA] = uv_act;
			rd_d[`TLS_S_PWR] = pwr_q;
			rd_d[`TLS_S_ALM] = alarm_q;
		end else if (paddr == `TLS_A_UV_THR) begin
			rd_d = 32'(thr_q);
		end else if (paddr == `TLS_A_MOT_MAX) begin
			rd_d = 32'(mmax_q);
		end else begin
			hit = 1'b0;
		end
	end

	// read data captured in the setup phase, stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= rd_d;
		end
	end

	// limit, percent, release and hold settings saturate to their range; all act at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fwd_int_q <= `TLS_INT_RST;
			rev_int_q <= `TLS_INT_RST;
			fwd_ext_q <= `TLS_EXT_RST;
			rev_ext_q <= `TLS_EXT_RST;
			uv_pct_q  <= `TLS_PCT_RST;
			uv_rel_q  <= `TLS_REL_RST;
			hold_q    <= `TLS_HOLD_RST;
			ctrl_q    <= 3'h0;
			in_a_q    <= `TLS_ALLOC_RST;
			in_b_q    <= `TLS_ALLOC_RST;
			out_q     <= `TLS_OUT_RST;
			thr_q     <= `TLS_THR_RST;
			mmax_q    <= `TLS_MMAX_RST;
		end else if (wr) begin
			if (paddr == `TLS_A_FWD_INT) begin
				fwd_int_q <= 9'(sat(pwdata, `TLS_LIM_MAX));
			end else if (paddr == `TLS_A_REV_INT) begin
				rev_int_q <= 9'(sat(pwdata, `TLS_LIM_MAX));
			end else if (paddr == `TLS_A_FWD_EXT) begin
				fwd_ext_q <= 9'(sat(pwdata, `TLS_LIM_MAX));
			end else if (paddr == `TLS_A_REV_EXT) begin
				rev_ext_q <= 9'(sat(pwdata, `TLS_LIM_MAX));
			end else if (paddr == `TLS_A_UV_PCT) begin
				uv_pct_q <= 7'(sat(pwdata, `TLS_PCT_MAX));
			end else if (paddr == `TLS_A_UV_REL) begin
				uv_rel_q <= 10'(sat(pwdata, `TLS_REL_MAX));
			end else if (paddr == `TLS_A_HOLD) begin
				hold_q <= 6'(sat(pwdata, `TLS_HOLD_MAX));
			end else if (paddr == `TLS_A_CTRL) begin
				ctrl_q <= pwdata[2:0];
			end else if (paddr == `TLS_A_IN_A) begin
				in_a_q <= pwdata[15:0];
			end else if (paddr == `TLS_A_IN_B) begin
				in_b_q <= pwdata[15:0];
			end else if (paddr == `TLS_A_OUT) begin
				out_q <= pwdata;
			end else if (paddr == `TLS_A_UV_THR) begin
				thr_q <= pwdata[11:0];
			end else if (paddr == `TLS_A_MOT_MAX) begin
				mmax_q <= 9'(sat(pwdata, `TLS_LIM_MAX));
			end
		end
	end

	// ----------------------------------------------------------
	// pin synchronisers and input allocation
	// ----------------------------------------------------------
	logic [NIN+1:0] s1_q, s2_q;
	logic [31:0]    in_codes;
	logic           fwd_req, rev_req;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {servo_on_in, supply_lost_in, din};
			s2_q <= s1_q;
		end
	end

	// later pins overwrite earlier ones: highest pin has priority
	assign in_codes = {in_b_q, in_a_q};
	always_comb begin
		fwd_req = 1'b0;
		rev_req = 1'b0;
		for (int i = 0; i < NIN; i++) begin
			if (in_codes[4*i +: 4] == `TLS_CODE_FWD) begin
				fwd_req = s2_q[i];
			end
			if (in_codes[4*i +: 4] == `TLS_CODE_REV) begin
				rev_req = s2_q[i];
			end
		end
	end

	// ----------------------------------------------------------
	// undervoltage detection and release timing
	// ----------------------------------------------------------
	logic [31:0] ms_div_q;
	logic [9:0]  ms_cnt_q;
	logic        ms_tick;

	// bus level comes from same-clock logic, so no synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uvw_q <= 1'b0;
		end else begin
			uvw_q <= (bus_level <= thr_q);
		end
	end

	assign ms_tick = (ms_div_q == 32'(MS_CYC - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_div_q <= 32'h00000000;
			ms_cnt_q <= 10'h000;
		end else if (uv_q != UV_RELEASE) begin
			ms_div_q <= 32'h00000000;
			ms_cnt_q <= 10'h000;
		end else if (ms_tick) begin
			ms_div_q <= 32'h00000000;
			ms_cnt_q <= ms_cnt_q + 10'h001;
		end else begin
			ms_div_q <= ms_div_q + 32'h00000001;
		end
	end

	// reduced limit stays until the release time has run out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_q <= UV_IDLE;
		end else begin
			case (uv_q)
				UV_IDLE: begin
					if (uvw_q) uv_q <= UV_ACTIVE;
				end
				UV_ACTIVE: begin
					if (!uvw_q) uv_q <= UV_RELEASE;
				end
				UV_RELEASE: begin
					if (uvw_q) begin
						uv_q <= UV_ACTIVE;
					end else if (ms_cnt_q >= uv_rel_q) begin
						uv_q <= UV_IDLE;
					end
				end
				default: uv_q <= UV_IDLE;
			endcase
		end
	end
	assign uv_act = (uv_q != UV_IDLE);

	// ----------------------------------------------------------
	// supply interruption hold and motor power
	// ----------------------------------------------------------
	logic [31:0] hd_div_q;
	logic [5:0]  hd_cnt_q;

	// counts whole supply cycles while the supply is missing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hd_div_q <= 32'h00000000;
			hd_cnt_q <= 6'h00;
		end else if (!s2_q[NIN]) begin
			hd_div_q <= 32'h00000000;
			hd_cnt_q <= 6'h00;
		end else if (hd_div_q == 32'(HOLD_CYC - 1)) begin
			hd_div_q <= 32'h00000000;
			if (hd_cnt_q != 6'h3F) hd_cnt_q <= hd_cnt_q + 6'h01;
		end else begin
			hd_div_q <= hd_div_q + 32'h00000001;
		end
	end

	// alarm is sticky; a new loss in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 1'b0;
		end else if (s2_q[NIN] && (hd_cnt_q >= hold_q)) begin
			alarm_q <= 1'b1;
		end else if (wr_stat && pwdata[`TLS_S_ALM]) begin
			alarm_q <= 1'b0;
		end
	end

	// servo off drops power on the next edge, no hold wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q <= 1'b0;
		end else begin
			pwr_q <= s2_q[NIN+1] & ~ctrl_q[`TLS_C_SOFF] & ~alarm_q;
		end
	end

	// ----------------------------------------------------------
	// limit selection and torque clamp
	// ----------------------------------------------------------
	tls_clamp_if fwd_if();
	tls_clamp_if rev_if();
	assign fwd_if.int_lim = fwd_int_q;
	assign fwd_if.ext_lim = fwd_ext_q;
	assign fwd_if.max_lim = mmax_q;
	assign fwd_if.uv_pct  = uv_pct_q;
	assign fwd_if.ext_req = fwd_req;
	assign fwd_if.uv_act  = uv_act;
	assign rev_if.int_lim = rev_int_q;
	assign rev_if.ext_lim = rev_ext_q;
	assign rev_if.max_lim = mmax_q;
	assign rev_if.uv_pct  = uv_pct_q;
	assign rev_if.ext_req = rev_req;
	assign rev_if.uv_act  = uv_act;

	tls_clamp u_fwd (.c(fwd_if));
	tls_clamp u_rev (.c(rev_if));

	logic signed [TW-1:0] pos_s, neg_s, cmd_d;

	// direction select swaps which sign counts as forward
	always_comb begin
		if (ctrl_q[`TLS_C_DIR]) begin
			pos_s = $signed(TW'(rev_if.lim));
			neg_s = $signed(TW'(fwd_if.lim));
		end else begin
			pos_s = $signed(TW'(fwd_if.lim));
			neg_s = $signed(TW'(rev_if.lim));
		end
		if (torque_ref > pos_s) begin
			cmd_d = pos_s;
		end else if (torque_ref < -neg_s) begin
			cmd_d = -neg_s;
		end else begin
			cmd_d = torque_ref;
		end
	end

	// re-evaluated every edge, so any limit change is seen at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_cmd <= '0;
			limit_q    <= 1'b0;
		end else begin
			torque_cmd <= cmd_d;
			limit_q    <= (cmd_d != torque_ref);
		end
	end

	// output pins: every pin coded for status follows it
	for (genvar k = 0; k < NOUT; k++) begin : g_out
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dout[k] <= 1'b0;
			end else begin
				dout[k] <= (out_q[4*k +: 4] == `TLS_CODE_CLT) &&
					(cmd_d != torque_ref);
			end
		end
	end

	assign limiting_status_out  = limit_q;
	assign undervoltage_warning = uvw_q;
	assign current_reduce_out   = uv_act;
	assign decay_slow_out       = uv_act & ctrl_q[`TLS_C_DECAY];
	assign motor_power_out      = pwr_q;
	assign alarm_stop_out       = alarm_q;

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	AST_EXT_ON: assert property (@(posedge pclk) disable iff (!presetn)
		fwd_req |-> fwd_if.lim <= fwd_int_q && fwd_if.lim <= fwd_ext_q)
		else $error("forward limit above selected settings");
	AST_EXT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!fwd_req && !uv_act && fwd_ext_q <= mmax_q |->
		fwd_if.lim == fwd_ext_q)
		else $error("forward limit not the external setting");
	AST_REV_ON: assert property (@(posedge pclk) disable iff (!presetn)
		rev_req |-> rev_if.lim <= rev_int_q && rev_if.lim <= rev_ext_q)
		else $error("reverse limit above selected settings");
	AST_MAX: assert property (@(posedge pclk) disable iff (!presetn)
		fwd_if.lim <= mmax_q && rev_if.lim <= mmax_q)
		else $error("limit above motor maximum");
	AST_CLT: assert property (@(posedge pclk) disable iff (!presetn)
		##1 limiting_status_out == (torque_cmd != $past(torque_ref)))
		else $error("status disagrees with clamping");
	AST_UVW: assert property (@(posedge pclk) disable iff (!presetn)
		bus_level <= thr_q |=> undervoltage_warning ##1 current_reduce_out)
		else $error("undervoltage not flagged");
	AST_REL: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(uvw_q) && uv_rel_q != 10'h000 |-> uv_act [*3])
		else $error("reduced limit released early");
	AST_SOFF: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_q[`TLS_C_SOFF] |=> !motor_power_out)
		else $error("power kept after servo off");
	AST_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == `TLS_A_FWD_INT && pwdata > `TLS_LIM_MAX |=>
		fwd_int_q == 9'(`TLS_LIM_MAX))
		else $error("internal limit not saturated");
endmodule
`default_nettype wire

/* File: design/tls_params.svh */
`ifndef TLS_PARAMS_SVH
`define TLS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TLS_A_FWD_INT   8'h00
`define TLS_A_REV_INT   8'h04
`define TLS_A_FWD_EXT   8'h08
`define TLS_A_REV_EXT   8'h0C
`define TLS_A_UV_PCT    8'h10
`define TLS_A_UV_REL    8'h14
`define TLS_A_HOLD      8'h18
`define TLS_A_CTRL      8'h1C
`define TLS_A_IN_A      8'h20
`define TLS_A_IN_B      8'h24
`define TLS_A_OUT       8'h28
`define TLS_A_STATUS    8'h2C
`define TLS_A_UV_THR    8'h30
`define TLS_A_MOT_MAX   8'h34

// ----------------------------------------------------------------
// ranges and reset values
// ----------------------------------------------------------------
`define TLS_LIM_MAX     32'h0000015E
`define TLS_INT_RST     9'h12C
`define TLS_EXT_RST     9'h064
`define TLS_PCT_MAX     32'h00000064
`define TLS_PCT_RST     7'h32
`define TLS_REL_MAX     32'h000003E8
`define TLS_REL_RST     10'h064
`define TLS_HOLD_MAX    32'h00000032
`define TLS_HOLD_RST    6'h01
`define TLS_THR_RST     12'h800
`define TLS_MMAX_RST    9'h15E
`define TLS_ALLOC_RST   16'hFFFF
`define TLS_OUT_RST     32'hFFFFFFFF
`define TLS_PCT_DIV     16'h0064

// ----------------------------------------------------------------
// allocation codes and field positions
// ----------------------------------------------------------------
`define TLS_CODE_FWD    4'h3
`define TLS_CODE_REV    4'h4
`define TLS_CODE_CLT    4'h3
`define TLS_C_DECAY     0
`define TLS_C_SOFF      1
`define TLS_C_DIR       2
`define TLS_S_CLT       0
`define TLS_S_UVW       1
`define TLS_S_UVA       2
`define TLS_S_PWR       3
`define TLS_S_ALM       4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TLS_CLK_NS      50
`define TLS_MS_NS       1000000
`define TLS_CYC_MS      20

`endif

/* File: design/tls_pkg.sv */
package tls_pkg;
	typedef logic [8:0] tls_lim_t;
	typedef logic [6:0] tls_pct_t;
	typedef enum logic [1:0] {
		UV_IDLE    = 2'b00,
		UV_ACTIVE  = 2'b01,
		UV_RELEASE = 2'b10
	} tls_uv_e;
endpackage

/* File: design/tls_clamp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tls_clamp_if;
	import tls_pkg::*;
	tls_lim_t int_lim;
	tls_lim_t ext_lim;
	tls_lim_t max_lim;
	tls_pct_t uv_pct;
	logic     ext_req;
	logic     uv_act;
	tls_lim_t lim;
	modport calc (input int_lim, ext_lim, max_lim, uv_pct, ext_req,
		uv_act, output lim);
	modport user (output int_lim, ext_lim, max_lim, uv_pct, ext_req,
		uv_act, input lim);
endinterface
`default_nettype wire

/* File: design/tls_clamp.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tls_params.svh"
module tls_clamp
	import tls_pkg::*;
(
	tls_clamp_if.calc c
);
	logic [15:0] prod;
	logic [15:0] uv_q16;

	// one direction: pick source, then undervoltage, then motor max
	always_comb begin
		prod   = 16'(c.int_lim) * 16'(c.uv_pct);
		uv_q16 = prod / `TLS_PCT_DIV;
		if (c.ext_req) begin
			c.lim = (c.ext_lim < c.int_lim) ? c.ext_lim : c.int_lim;
		end else begin
			c.lim = c.ext_lim;
		end
		if (c.uv_act && (uv_q16[8:0] < c.lim)) begin
			c.lim = uv_q16[8:0];
		end
		if (c.max_lim < c.lim) begin
			c.lim = c.max_lim;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tls_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host controller driving the discrete pins
// ----------------------------------------------------------------
module tls_host_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       fwd_on,
	input  wire logic       rev_on,
	input  wire logic       run,
	input  wire logic       mains_ok,
	output logic      [4:0] din,
	output logic            servo_on_in,
	output logic            supply_lost_in
);
	// pins 0 and 1 carry the requests; open contacts read as off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din            <= 5'h00;
			servo_on_in    <= 1'b0;
			supply_lost_in <= 1'b0;
		end else begin
			din            <= {3'h0, rev_on, fwd_on};
			servo_on_in    <= run;
			supply_lost_in <= !mains_ok;
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tls_params.svh"
module tb;
	import tls_pkg::*;
	logic               pclk;
	logic               presetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [4:0]         din;
	logic [2:0]         dout;
	logic               servo_on_in;
	logic               supply_lost_in;
	logic [11:0]        bus_level;
	logic signed [15:0] torque_ref;
	logic signed [15:0] torque_cmd;
	logic               lim_st;
	logic               uv_warn;
	logic               cur_red;
	logic               decay;
	logic               mpow;
	logic               alarm;
	logic               fwd_on;
	logic               rev_on;
	logic               run;
	logic               mains_ok;
	int                 failures;
	int                 num_checks;
	int                 cycles;
	logic [31:0]        v;
	logic               e;
	logic [31:0]        rv [14] = '{32'h12C, 32'h12C, 32'h64, 32'h64,
		32'h32, 32'h64, 32'h1, 32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFFFFFF,
		32'h0, 32'h800, 32'h15E};

	tls_top #(.MS_CYC(4), .HOLD_CYC(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .din(din), .dout(dout),
		.servo_on_in(servo_on_in), .supply_lost_in(supply_lost_in),
		.bus_level(bus_level), .torque_ref(torque_ref),
		.torque_cmd(torque_cmd), .limiting_status_out(lim_st),
		.undervoltage_warning(uv_warn), .current_reduce_out(cur_red),
		.decay_slow_out(decay), .motor_power_out(mpow),
		.alarm_stop_out(alarm));

	tls_host_model host_u (
		.pclk(pclk), .presetn(presetn), .fwd_on(fwd_on), .rev_on(rev_on),
		.run(run), .mains_ok(mains_ok), .din(din),
		.servo_on_in(servo_on_in), .supply_lost_in(supply_lost_in));

	// ----------------------------------------------------------------
	// clock, hang guard and reporting
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// whole run needs about 300 cycles; 6000 leaves margin
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------------------------------
	// bus and torque helpers
	// ----------------------------------------------------------------
	// entered just after an edge; leaves one idle cycle behind
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50)
			chk(32'h0, 32'h1);
		v = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(v, exp);
	endtask

	// pins need two sync edges plus the registered output
	task automatic tq(input int r, input int c, input logic s);
		torque_ref <= 16'(r);
		repeat (5) @(posedge pclk);
		chk(32'(torque_cmd), 32'(c));
		chk(32'(lim_st), 32'(s));
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		bus_level = 12'hFFF;
		torque_ref = 16'h0000;
		fwd_on = 1'b0;
		rev_on = 1'b0;
		run = 1'b0;
		mains_ok = 1'b1;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);

		// reset values of every register, then an unmapped word
		for (int i = 0; i < 14; i++)
			rdc(8'(4 * i), rv[i]);
		apb(1'b0, 8'h3C, 32'h0);
		chk(32'(e), 32'h1);
		chk(v, 32'h0);
		// out-of-range writes saturate at the top of each range
		apb(1'b1, `TLS_A_FWD_INT, 32'h1FF);
		rdc(`TLS_A_FWD_INT, 32'h15E);
		apb(1'b1, `TLS_A_REV_EXT, 32'h200);
		rdc(`TLS_A_REV_EXT, 32'h15E);
		apb(1'b1, `TLS_A_UV_PCT, 32'hC8);
		rdc(`TLS_A_UV_PCT, 32'h64);
		apb(1'b1, `TLS_A_UV_REL, 32'h7D0);
		rdc(`TLS_A_UV_REL, 32'h3E8);
		apb(1'b1, `TLS_A_HOLD, 32'h63);
		rdc(`TLS_A_HOLD, 32'h32);
		$display("test registers done");

		// requests routed by codes 3 and 4; status on out pin 0
		apb(1'b1, `TLS_A_FWD_INT, 32'h12C);
		apb(1'b1, `TLS_A_REV_EXT, 32'h64);
		apb(1'b1, `TLS_A_IN_A, 32'hFF43);
		apb(1'b1, `TLS_A_OUT, 32'hFFFFFFF3);
		tq(400, 100, 1'b1);
		chk(32'(dout), 32'h1);
		tq(100, 100, 1'b0);
		chk(32'(dout), 32'h0);
		tq(-400, -100, 1'b1);
		apb(1'b1, `TLS_A_FWD_EXT, 32'h15E);
		tq(400, 350, 1'b1);
		fwd_on <= 1'b1;
		tq(400, 300, 1'b1);
		apb(1'b1, `TLS_A_FWD_INT, 32'hC8);
		tq(400, 200, 1'b1);
		apb(1'b1, `TLS_A_FWD_INT, 32'h12C);
		rev_on <= 1'b1;
		tq(-400, -100, 1'b1);
		apb(1'b1, `TLS_A_REV_EXT, 32'h15E);
		tq(-400, -300, 1'b1);
		tq(-250, -250, 1'b0);
		apb(1'b1, `TLS_A_MOT_MAX, 32'h96);
		tq(400, 150, 1'b1);
		apb(1'b1, `TLS_A_MOT_MAX, 32'h15E);
		// direction select: positive side now takes the reverse limit
		apb(1'b1, `TLS_A_CTRL, 32'h4);
		apb(1'b1, `TLS_A_REV_INT, 32'hC8);
		tq(400, 200, 1'b1);
		tq(-400, -300, 1'b1);
		apb(1'b1, `TLS_A_REV_INT, 32'h12C);
		apb(1'b1, `TLS_A_CTRL, 32'h0);
		$display("test limits done");

		// undervoltage: 80 percent of 300, held 2 ms after recovery
		apb(1'b1, `TLS_A_UV_PCT, 32'h50);
		apb(1'b1, `TLS_A_UV_REL, 32'h2);
		apb(1'b1, `TLS_A_CTRL, 32'h1);
		bus_level <= 12'h100;
		tq(400, 240, 1'b1);
		chk(32'(uv_warn), 32'h1);
		chk(32'(cur_red), 32'h1);
		chk(32'(decay), 32'h1);
		tq(-400, -240, 1'b1);
		bus_level <= 12'hFFF;
		repeat (3) @(posedge pclk);
		chk(32'(uv_warn), 32'h0);
		chk(32'(cur_red), 32'h1);
		chk(32'(torque_cmd), -32'sd240);
		repeat (20) @(posedge pclk);
		chk(32'(cur_red), 32'h0);
		chk(32'(decay), 32'h0);
		tq(400, 300, 1'b1);
		$display("test undervoltage done");

		// supply loss rides through one cycle, then alarms
		apb(1'b1, `TLS_A_CTRL, 32'h0);
		// hold was left saturated at 50 by the range test
		apb(1'b1, `TLS_A_HOLD, 32'h1);
		run <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(32'(mpow), 32'h1);
		mains_ok <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(32'(alarm), 32'h0);
		chk(32'(mpow), 32'h1);
		repeat (20) @(posedge pclk);
		chk(32'(alarm), 32'h1);
		chk(32'(mpow), 32'h0);
		mains_ok <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b1, `TLS_A_STATUS, 32'h10);
		repeat (3) @(posedge pclk);
		chk(32'(alarm), 32'h0);
		chk(32'(mpow), 32'h1);
		apb(1'b1, `TLS_A_CTRL, 32'h2);
		repeat (2) @(posedge pclk);
		chk(32'(mpow), 32'h0);
		$display("test supply done");
		give_verdict();
	end
endmodule
`default_nettype wire
